// *** design/iau_core.v ***
// integer arithmetic execution unit: decode, flag, divide signs, accumulator
// assumes: decode stage supplies register values and memory operands in the
// issue cycle and holds the instruction while BUSY is high
//
// Functional notes
// - add register or immediate into destination, flag untouched.
// - add with carry sums operands and flag, carry out to flag.
// - add with overflow check writes sum, signed overflow to flag.
// - compare equal on reg_zero versus immediate or register pair.
// - unsigned higher-or-same and higher compares set or clear flag.
// - signed greater-or-equal and greater compares set or clear flag.
// - compare positive and nonnegative test one register against zero.
// - any matching byte lane between two registers sets flag.
// - signed divide init copies both sign bits, flag gets their xor.
// - unsigned divide init clears both sign bits and flag.
// - divide step does one non-restoring step, quotient bit into flag.
// - double multiplies give full 64-bit signed or unsigned product.
// - decrement register, flag set only when result is zero.
// - sign or zero extend low byte or word into destination.
// - long multiply-accumulate adds signed 32-bit product, addresses plus 4.
// - word multiply-accumulate adds signed 16-bit product, addresses plus 2.
// - long low multiply writes only low 32 product bits.
// - 16-bit multiplies write signed or unsigned 32-bit product.
// - negate, and negate with borrow which loads borrow into flag.
// - subtract, and subtract with borrow which loads borrow into flag.
// - subtract with underflow check sets flag on signed underflow.
// - multiplies take two or one states, five or three if result read.
`timescale 1ns/1ps
`default_nettype none
`include "iau_regs.vh"

module iau_core (
  input wire CORE_CLK, // core clock, 40 MHz
  input wire RST_B, // synchronous reset, active low
  input wire INSN_VALID, // instruction offered this cycle
  input wire [15:0] INSN, // instruction code
  input wire [31:0] RN_VAL, // destination register value
  input wire [31:0] RM_VAL, // source register value
  input wire [31:0] R0_VAL, // reg_zero value
  input wire [31:0] MEM_N, // memory word at destination address
  input wire [31:0] MEM_M, // memory word at source address
  input wire NEXT_READS_ACC, // following instruction reads accumulator
  output reg WB_EN, // destination write-back strobe
  output reg [3:0] WB_IDX, // destination register index
  output reg [31:0] WB_DATA, // destination write-back data
  output reg WB2_EN, // source write-back strobe
  output reg [3:0] WB2_IDX, // source register index
  output reg [31:0] WB2_DATA, // source write-back data
  output reg COND_FLAG, // cond_flag
  output reg DIVIDEND_SIGN, // dividend_sign
  output reg DIVISOR_SIGN, // divisor_sign
  output reg [31:0] PRODUCT_HIGH, // product_high
  output reg [31:0] PRODUCT_LOW, // product_low
  output wire BUSY // stall, instruction not taken
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function [32:0] add33;
    input [31:0] a;
    input [31:0] b;
    input cin;
    begin
      add33 = {1'b0, a} + {1'b0, b} + {32'h0000_0000, cin};
    end
  endfunction

  function [32:0] sub33;
    input [31:0] a;
    input [31:0] b;
    input bin;
    begin
      sub33 = {1'b0, a} - {1'b0, b} - {32'h0000_0000, bin};
    end
  endfunction

  function sext_ge;
    input [31:0] a;
    input [31:0] b;
    begin
      sext_ge = ($signed(a) >= $signed(b));
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode

  wire busy_w;
  wire take;
  wire [3:0] rn_idx;
  wire [3:0] rm_idx;
  wire [63:0] mul_p;
  wire [31:0] imm_sx;

  assign take = INSN_VALID & ~busy_w;
  assign rn_idx = INSN[`IAU_FLD_N_HI:`IAU_FLD_N_LO];
  assign rm_idx = INSN[`IAU_FLD_M_HI:`IAU_FLD_M_LO];
  assign imm_sx = {{24{INSN[7]}}, INSN[7:0]};
  assign BUSY = busy_w;

  reg wb_en_d;
  reg [31:0] wb_data_d;
  reg wb2_en_d;
  reg [31:0] wb2_data_d;
  reg flag_d;
  reg dsign_d;
  reg vsign_d;
  reg mul_start;
  reg mul_sgn;
  reg [31:0] mul_a;
  reg [31:0] mul_b;
  reg [2:0] mul_states;
  reg acc_full;
  reg acc_add;
  reg acc_low;
  reg [32:0] t33;
  reg [31:0] shl;
  reg [63:0] acc_sum;

  always @* begin
    wb_en_d = 1'b0;
    wb_data_d = 32'h0000_0000;
    wb2_en_d = 1'b0;
    wb2_data_d = 32'h0000_0000;
    flag_d = COND_FLAG;
    dsign_d = DIVIDEND_SIGN;
    vsign_d = DIVISOR_SIGN;
    mul_start = 1'b0;
    mul_sgn = 1'b1;
    mul_a = RN_VAL;
    mul_b = RM_VAL;
    mul_states = NEXT_READS_ACC ? `IAU_LONG_STATES_DEP
                                : `IAU_LONG_STATES;
    acc_full = 1'b0;
    acc_add = 1'b0;
    acc_low = 1'b0;
    t33 = 33'h0_0000_0000;
    shl = 32'h0000_0000;
    casez (INSN)
      `IAU_OP_ADD: begin
        wb_en_d = 1'b1;
        wb_data_d = RN_VAL + RM_VAL;
      end
      `IAU_OP_ADDI: begin
        wb_en_d = 1'b1;
        wb_data_d = RN_VAL + imm_sx;
      end
      `IAU_OP_ADD_WITH_CARRY: begin
        t33 = add33(RN_VAL, RM_VAL, COND_FLAG);
        wb_en_d = 1'b1;
        wb_data_d = t33[31:0];
        flag_d = t33[32];
      end
      `IAU_OP_ADD_CHECK_OVERFLOW: begin
        t33 = add33(RN_VAL, RM_VAL, 1'b0);
        wb_en_d = 1'b1;
        wb_data_d = t33[31:0];
        flag_d = (RN_VAL[31] == RM_VAL[31]) &
                 (t33[31] != RN_VAL[31]);
      end
      `IAU_OP_CMPEQI: flag_d = (R0_VAL == imm_sx);
      `IAU_OP_CMPEQ: flag_d = (RN_VAL == RM_VAL);
      `IAU_OP_CMPHS: flag_d = (RN_VAL >= RM_VAL);
      `IAU_OP_CMPHI: flag_d = (RN_VAL > RM_VAL);
      `IAU_OP_CMPGE: flag_d = sext_ge(RN_VAL, RM_VAL);
      `IAU_OP_CMPGT: flag_d = sext_ge(RN_VAL, RM_VAL) &
                              (RN_VAL != RM_VAL);
      `IAU_OP_CMPPL: flag_d = sext_ge(RN_VAL, 32'h0000_0001);
      `IAU_OP_CMPPZ: flag_d = ~RN_VAL[31];
      `IAU_OP_CMPSTR: begin
        flag_d = (RN_VAL[31:24] == RM_VAL[31:24]) |
                 (RN_VAL[23:16] == RM_VAL[23:16]) |
                 (RN_VAL[15:8] == RM_VAL[15:8]) |
                 (RN_VAL[7:0] == RM_VAL[7:0]);
      end
      `IAU_OP_DIVSTEP: begin
        // quotient bit moves in from the flag, divisor added or taken away
        shl = {RN_VAL[30:0], COND_FLAG};
        if (DIVIDEND_SIGN == DIVISOR_SIGN) begin
          t33 = sub33(shl, RM_VAL, 1'b0);
        end else begin
          t33 = add33(shl, RM_VAL, 1'b0);
        end
        wb_en_d = 1'b1;
        wb_data_d = t33[31:0];
        dsign_d = RN_VAL[31] ^ t33[32] ^ DIVISOR_SIGN;
        flag_d = ~(RN_VAL[31] ^ t33[32]);
      end
      `IAU_OP_DIVINS: begin
        dsign_d = RN_VAL[31];
        vsign_d = RM_VAL[31];
        flag_d = RN_VAL[31] ^ RM_VAL[31];
      end
      `IAU_OP_DIVINU: begin
        dsign_d = 1'b0;
        vsign_d = 1'b0;
        flag_d = 1'b0;
      end
      `IAU_OP_DMULS: begin
        mul_start = 1'b1;
        acc_full = 1'b1;
      end
      `IAU_OP_DMULU: begin
        mul_start = 1'b1;
        mul_sgn = 1'b0;
        acc_full = 1'b1;
      end
      `IAU_OP_DECT: begin
        wb_en_d = 1'b1;
        wb_data_d = RN_VAL - 32'h0000_0001;
        flag_d = (RN_VAL == 32'h0000_0001);
      end
      `IAU_OP_SEXTB: begin
        wb_en_d = 1'b1;
        wb_data_d = {{24{RM_VAL[7]}}, RM_VAL[7:0]};
      end
      `IAU_OP_SEXTW: begin
        wb_en_d = 1'b1;
        wb_data_d = {{16{RM_VAL[15]}}, RM_VAL[15:0]};
      end
      `IAU_OP_ZEXTB: begin
        wb_en_d = 1'b1;
        wb_data_d = {24'h00_0000, RM_VAL[7:0]};
      end
      `IAU_OP_ZEXTW: begin
        wb_en_d = 1'b1;
        wb_data_d = {16'h0000, RM_VAL[15:0]};
      end
      `IAU_OP_PRODUCT_LOW: begin
        mul_start = 1'b1;
        mul_a = MEM_N;
        mul_b = MEM_M;
        acc_add = 1'b1;
        wb_en_d = 1'b1;
        wb_data_d = RN_VAL + `IAU_PRODUCT_LOW_STEP;
        wb2_en_d = 1'b1;
        wb2_data_d = RM_VAL + `IAU_PRODUCT_LOW_STEP;
      end
      `IAU_OP_MACW: begin
        mul_start = 1'b1;
        mul_a = {{16{MEM_N[15]}}, MEM_N[15:0]};
        mul_b = {{16{MEM_M[15]}}, MEM_M[15:0]};
        acc_add = 1'b1;
        wb_en_d = 1'b1;
        wb_data_d = RN_VAL + `IAU_MACW_STEP;
        wb2_en_d = 1'b1;
        wb2_data_d = RM_VAL + `IAU_MACW_STEP;
      end
      `IAU_OP_MULL: begin
        mul_start = 1'b1;
        acc_low = 1'b1;
      end
      `IAU_OP_MULSW: begin
        mul_start = 1'b1;
        mul_a = {{16{RN_VAL[15]}}, RN_VAL[15:0]};
        mul_b = {{16{RM_VAL[15]}}, RM_VAL[15:0]};
        mul_states = NEXT_READS_ACC ? `IAU_SHORT_STATES_DEP
                                    : `IAU_SHORT_STATES;
        acc_low = 1'b1;
      end
      `IAU_OP_MULUW: begin
        mul_start = 1'b1;
        mul_sgn = 1'b0;
        mul_a = {16'h0000, RN_VAL[15:0]};
        mul_b = {16'h0000, RM_VAL[15:0]};
        mul_states = NEXT_READS_ACC ? `IAU_SHORT_STATES_DEP
                                    : `IAU_SHORT_STATES;
        acc_low = 1'b1;
      end
      `IAU_OP_NEG: begin
        wb_en_d = 1'b1;
        wb_data_d = 32'h0000_0000 - RM_VAL;
      end
      `IAU_OP_NEGATE_WITH_BORROW: begin
        t33 = sub33(32'h0000_0000, RM_VAL, COND_FLAG);
        wb_en_d = 1'b1;
        wb_data_d = t33[31:0];
        flag_d = t33[32];
      end
      `IAU_OP_SUB: begin
        wb_en_d = 1'b1;
        wb_data_d = RN_VAL - RM_VAL;
      end
      `IAU_OP_SUB_WITH_BORROW: begin
        t33 = sub33(RN_VAL, RM_VAL, COND_FLAG);
        wb_en_d = 1'b1;
        wb_data_d = t33[31:0];
        flag_d = t33[32];
      end
      `IAU_OP_SUB_CHECK_UNDERFLOW: begin
        t33 = sub33(RN_VAL, RM_VAL, 1'b0);
        wb_en_d = 1'b1;
        wb_data_d = t33[31:0];
        flag_d = (RN_VAL[31] != RM_VAL[31]) &
                 (t33[31] != RN_VAL[31]);
      end
      default: begin
        flag_d = COND_FLAG;
      end
    endcase
    acc_sum = {PRODUCT_HIGH, PRODUCT_LOW} + mul_p;
  end

  ////////////////////////////////////////////////////////////////////////////
  // multiplier and stall counter

  iau_mul #(
    .WIDTH(32),
    .CW(3)
  ) u_mul (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .start(take & mul_start),
    .sgn(mul_sgn),
    .a(mul_a),
    .b(mul_b),
    .states(mul_states),
    .product(mul_p),
    .busy_q(busy_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // architectural state and write-back registers

  always @(posedge CORE_CLK) begin
    if (!RST_B) begin
      WB_EN <= 1'b0;
      WB_IDX <= 4'h0;
      WB_DATA <= 32'h0000_0000;
      WB2_EN <= 1'b0;
      WB2_IDX <= 4'h0;
      WB2_DATA <= 32'h0000_0000;
      COND_FLAG <= `IAU_FLAG_RST;
      DIVIDEND_SIGN <= 1'b0;
      DIVISOR_SIGN <= 1'b0;
      PRODUCT_HIGH <= `IAU_ACC_RST;
      PRODUCT_LOW <= `IAU_ACC_RST;
    end else begin
      WB_EN <= take & wb_en_d;
      WB_IDX <= rn_idx;
      WB_DATA <= wb_data_d;
      WB2_EN <= take & wb2_en_d;
      WB2_IDX <= rm_idx;
      WB2_DATA <= wb2_data_d;
      if (take) begin
        COND_FLAG <= flag_d;
        DIVIDEND_SIGN <= dsign_d;
        DIVISOR_SIGN <= vsign_d;
        if (acc_full) begin
          PRODUCT_HIGH <= mul_p[63:32];
          PRODUCT_LOW <= mul_p[31:0];
        end else if (acc_add) begin
          PRODUCT_HIGH <= acc_sum[63:32];
          PRODUCT_LOW <= acc_sum[31:0];
        end else if (acc_low) begin
          PRODUCT_LOW <= mul_p[31:0];
        end
      end
    end
  end

endmodule // iau_core

`default_nettype wire

// *** design/iau_mul.v ***
// multiplier with issue-stall counter for the integer arithmetic unit
// assumes: operands steady during the start cycle; one clock, sync reset
`timescale 1ns/1ps
`default_nettype none

module iau_mul #(
  parameter WIDTH = 32,
  parameter CW = 3
) (
  input wire clk, // core clock
  input wire rst_b, // synchronous reset, active low
  input wire start, // multiply issued this cycle
  input wire sgn, // operands are signed
  input wire [WIDTH-1:0] a, // first operand
  input wire [WIDTH-1:0] b, // second operand
  input wire [CW-1:0] states, // execution states of this multiply
  output wire [2*WIDTH-1:0] product, // full product, combinational
  output reg busy_q // stall while further states remain
);

  reg [CW-1:0] cnt_q;
  wire [2*WIDTH-1:0] a_ext;
  wire [2*WIDTH-1:0] b_ext;
  wire [2*WIDTH-1:0] full;

  assign a_ext = {{WIDTH{sgn & a[WIDTH-1]}}, a};
  assign b_ext = {{WIDTH{sgn & b[WIDTH-1]}}, b};
  assign full = a_ext * b_ext;
  // product taken modulo 2**(2*WIDTH), exact for both signed and unsigned
  assign product = full;

  ////////////////////////////////////////////////////////////////////////////
  // counts the states after the issue state
  always @(posedge clk) begin
    if (!rst_b) begin
      cnt_q <= {CW{1'b0}};
      busy_q <= 1'b0;
    end else if (start) begin
      cnt_q <= states - {{(CW-1){1'b0}}, 1'b1};
      busy_q <= (states > {{(CW-1){1'b0}}, 1'b1});
    end else if (cnt_q != {CW{1'b0}}) begin
      cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
      busy_q <= (cnt_q > {{(CW-1){1'b0}}, 1'b1});
    end
  end

endmodule // iau_mul

`default_nettype wire

// *** design/iau_regs.vh ***
// opcode patterns and timing counts for the integer arithmetic unit
// assumes: included by the arithmetic unit files only
`ifndef IAU_REGS_VH
`define IAU_REGS_VH

// instruction encodings, ? marks register or immediate fields
`define IAU_OP_ADD      16'b0011_????_????_1100
`define IAU_OP_ADDI     16'b0111_????_????_????
`define IAU_OP_ADD_WITH_CARRY     16'b0011_????_????_1110
`define IAU_OP_ADD_CHECK_OVERFLOW     16'b0011_????_????_1111
`define IAU_OP_CMPEQI   16'b1000_1000_????_????
`define IAU_OP_CMPEQ    16'b0011_????_????_0000
`define IAU_OP_CMPHS    16'b0011_????_????_0010
`define IAU_OP_CMPGE    16'b0011_????_????_0011
`define IAU_OP_CMPHI    16'b0011_????_????_0110
`define IAU_OP_CMPGT    16'b0011_????_????_0111
`define IAU_OP_CMPPL    16'b0100_????_0001_0101
`define IAU_OP_CMPPZ    16'b0100_????_0001_0001
`define IAU_OP_CMPSTR   16'b0010_????_????_1100
`define IAU_OP_DIVSTEP  16'b0011_????_????_0100
`define IAU_OP_DIVINS   16'b0010_????_????_0111
`define IAU_OP_DIVINU   16'b0000_0000_0001_1001
`define IAU_OP_DMULS    16'b0011_????_????_1101
`define IAU_OP_DMULU    16'b0011_????_????_0101
`define IAU_OP_DECT     16'b0100_????_0001_0000
`define IAU_OP_SEXTB    16'b0110_????_????_1110
`define IAU_OP_SEXTW    16'b0110_????_????_1111
`define IAU_OP_ZEXTB    16'b0110_????_????_1100
`define IAU_OP_ZEXTW    16'b0110_????_????_1101
`define IAU_OP_PRODUCT_LOW     16'b0000_????_????_1111
`define IAU_OP_MACW     16'b0100_????_????_1111
`define IAU_OP_MULL     16'b0000_????_????_0111
`define IAU_OP_MULSW    16'b0010_????_????_1111
`define IAU_OP_MULUW    16'b0010_????_????_1110
`define IAU_OP_NEG      16'b0110_????_????_1011
`define IAU_OP_NEGATE_WITH_BORROW     16'b0110_????_????_1010
`define IAU_OP_SUB      16'b0011_????_????_1000
`define IAU_OP_SUB_WITH_BORROW     16'b0011_????_????_1010
`define IAU_OP_SUB_CHECK_UNDERFLOW     16'b0011_????_????_1011

// field positions
`define IAU_FLD_N_HI    11
`define IAU_FLD_N_LO    8
`define IAU_FLD_M_HI    7
`define IAU_FLD_M_LO    4

// execution states of the multiplies, plain and with accumulator read next
`define IAU_LONG_STATES      3'h2
`define IAU_LONG_STATES_DEP  3'h5
`define IAU_SHORT_STATES     3'h1
`define IAU_SHORT_STATES_DEP 3'h3

// address steps of the multiply-accumulates
`define IAU_PRODUCT_LOW_STEP   32'h0000_0004
`define IAU_MACW_STEP   32'h0000_0002

// reset values
`define IAU_FLAG_RST    1'b0
`define IAU_ACC_RST     32'h0000_0000

`endif

// *** tb/iau_core_assertions.sv ***
// checker for the arithmetic unit: stall counts, flag and sign results
// assumes: bound into iau_core, sees its ports only
`timescale 1ns/1ps
`default_nettype none
`include "iau_regs.vh"

module iau_core_assertions (
  input wire logic CORE_CLK, // core clock
  input wire logic RST_B, // sync reset, active low
  input wire logic INSN_VALID, // instruction offered
  input wire logic [15:0] INSN, // instruction code
  input wire logic [31:0] RN_VAL, // register n
  input wire logic [31:0] RM_VAL, // register m
  input wire logic NEXT_READS_ACC, // accumulator read next
  input wire logic WB_EN, // write strobe n
  input wire logic WB2_EN, // write strobe m
  input wire logic COND_FLAG, // cond_flag
  input wire logic DIVIDEND_SIGN, // dividend_sign
  input wire logic DIVISOR_SIGN, // divisor_sign
  input wire logic BUSY // stall
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  wire logic take = INSN_VALID && !BUSY;
  wire logic mac_op = INSN ==? `IAU_OP_PRODUCT_LOW || INSN ==? `IAU_OP_MACW;
  wire logic long_op = mac_op || INSN ==? `IAU_OP_MULL ||
    INSN ==? `IAU_OP_DMULS || INSN ==? `IAU_OP_DMULU;
  wire logic short_op = INSN ==? `IAU_OP_MULSW || INSN ==? `IAU_OP_MULUW;

  ////////////////////////////////////////////////////////////////////////
  a_long_plain:
    assert property (take && long_op && !NEXT_READS_ACC |=> BUSY ##1 !BUSY)
    else $error("long multiply stall not one cycle");
  a_long_dep:
    assert property (take && long_op && NEXT_READS_ACC |=>
      BUSY [*4] ##1 !BUSY) else $error("long multiply stall not four");
  a_short_plain:
    assert property (take && short_op && !NEXT_READS_ACC |=> !BUSY)
    else $error("short multiply stalled");
  a_short_dep:
    assert property (take && short_op && NEXT_READS_ACC |=>
      BUSY [*2] ##1 !BUSY) else $error("short multiply stall not two");
  a_single_state:
    assert property (take && !long_op && !short_op |=> !BUSY)
    else $error("single state operation stalled");
  a_flag_kept:
    assert property (take && (INSN ==? `IAU_OP_ADD || INSN ==? `IAU_OP_SUB
      || INSN ==? `IAU_OP_NEG) |=> $stable(COND_FLAG))
    else $error("flag changed by add, subtract or negate");
  a_cmp_equal:
    assert property (take && INSN ==? `IAU_OP_CMPEQ |=>
      COND_FLAG == ($past(RN_VAL) == $past(RM_VAL)))
    else $error("equal compare flag wrong");
  a_div_signs:
    assert property (take && INSN ==? `IAU_OP_DIVINS |=>
      DIVIDEND_SIGN == $past(RN_VAL[31]) && DIVISOR_SIGN == $past(RM_VAL[31])
      && COND_FLAG == ($past(RN_VAL[31]) ^ $past(RM_VAL[31])))
    else $error("signed divide init wrong");
  a_div_clear:
    assert property (take && INSN ==? `IAU_OP_DIVINU |=>
      !COND_FLAG && !DIVIDEND_SIGN && !DIVISOR_SIGN)
    else $error("unsigned divide init left bits set");
  a_dec_flag:
    assert property (take && INSN ==? `IAU_OP_DECT |=>
      COND_FLAG == ($past(RN_VAL) == 32'h1))
    else $error("decrement test flag wrong");
  a_mac_writes:
    assert property (take && mac_op |=> WB_EN && WB2_EN)
    else $error("accumulate did not write both addresses");
  c_long_dep: cover property (take && long_op && NEXT_READS_ACC);
  c_short_dep: cover property (take && short_op && NEXT_READS_ACC);
  c_mac: cover property (take && mac_op);
endmodule // iau_core_assertions
`default_nettype wire

// *** tb/iau_regfile_model.sv ***
// register file and memory stand-in on the decode side of the unit
// assumes: one clock; write-backs land on its rising edge
`timescale 1ns/1ps
`default_nettype none

module iau_regfile_model (
  input wire logic CORE_CLK, // core clock
  input wire logic [15:0] INSN, // instruction on offer
  input wire logic WB_EN, // write n
  input wire logic [3:0] WB_IDX, // index n
  input wire logic [31:0] WB_DATA, // data n
  input wire logic WB2_EN, // write m
  input wire logic [3:0] WB2_IDX, // index m
  input wire logic [31:0] WB2_DATA, // data m
  output logic [31:0] RN_VAL, // register n
  output logic [31:0] RM_VAL, // register m
  output logic [31:0] R0_VAL, // reg_zero
  output logic [31:0] MEM_N, // word at address in n
  output logic [31:0] MEM_M // word at address in m
);
  logic [31:0] regs [0:15];
  initial for (int i = 0; i < 16; i++) regs[i] = 32'h0;
  assign RN_VAL = regs[INSN[11:8]];
  assign RM_VAL = regs[INSN[7:4]];
  assign R0_VAL = regs[0];
  // memory word is its address shifted down, easy to predict
  assign MEM_N = RN_VAL >> 4;
  assign MEM_M = RM_VAL >> 4;
  always @(posedge CORE_CLK) begin
    if (WB_EN) regs[WB_IDX] <= WB_DATA;
    if (WB2_EN) regs[WB2_IDX] <= WB2_DATA;
  end
endmodule // iau_regfile_model
`default_nettype wire

// *** tb/test_integer_arith_unit.sv ***
// self-checking bench for the integer arithmetic unit
// assumes: iau_core with the register file model on its decode side
`timescale 1ns/1ps
`default_nettype none

module test_integer_arith_unit;
  logic CORE_CLK = 1'b0;
  logic RST_B = 1'b0;
  logic INSN_VALID = 1'b0;
  logic [15:0] INSN = 16'h0;
  logic NEXT_READS_ACC = 1'b0;
  wire logic [31:0] RN_VAL, RM_VAL, R0_VAL, MEM_N, MEM_M;
  wire logic WB_EN, WB2_EN, COND_FLAG, DIVIDEND_SIGN, DIVISOR_SIGN, BUSY;
  wire logic [3:0] WB_IDX, WB2_IDX;
  wire logic [31:0] WB_DATA, WB2_DATA, PRODUCT_HIGH, PRODUCT_LOW;
  int err_count = 0;
  int comparisons = 0;
  logic [31:0] wbd, wb2d;

  initial forever #12.5 CORE_CLK = ~CORE_CLK;

  iau_core dut (.CORE_CLK, .RST_B, .INSN_VALID, .INSN, .RN_VAL, .RM_VAL,
    .R0_VAL, .MEM_N, .MEM_M, .NEXT_READS_ACC, .WB_EN, .WB_IDX, .WB_DATA,
    .WB2_EN, .WB2_IDX, .WB2_DATA, .COND_FLAG, .DIVIDEND_SIGN, .DIVISOR_SIGN,
    .PRODUCT_HIGH, .PRODUCT_LOW, .BUSY);
  iau_regfile_model model (.CORE_CLK, .INSN, .WB_EN, .WB_IDX, .WB_DATA,
    .WB2_EN, .WB2_IDX, .WB2_DATA, .RN_VAL, .RM_VAL, .R0_VAL, .MEM_N, .MEM_M);

  //////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      err_count++;
    end
  endtask

  // offers a code, returns 1 ns after its taking edge; valid stays up
  task automatic issue(input logic [15:0] code, input logic nra);
    int i;
    INSN = code;
    NEXT_READS_ACC = nra;
    INSN_VALID = 1'b1;
    for (i = 0; i < 8 && BUSY !== 1'b0; i++) @(posedge CORE_CLK) #1;
    if (i == 8) begin
      chk(BUSY, 64'h0);
      test_done;
    end
    @(posedge CORE_CLK) #1;
  endtask

  // presets the flag with an equal compare, then runs one operation
  task automatic op(input logic [15:0] code, input logic tin,
      input logic [31:0] a, b, input logic wb, input logic [31:0] ew,
      input logic ef);
    model.regs[1] = 32'h0;
    model.regs[2] = {31'h0, !tin};
    issue(16'h3120, 1'b0);
    model.regs[0] = a;
    model.regs[1] = a;
    model.regs[2] = b;
    issue(code, 1'b0);
    chk({WB2_EN, WB_IDX}, {1'b0, code[11:8]});
    chk(WB_EN, wb);
    if (wb) chk(WB_DATA, ew);
    chk(COND_FLAG, ef);
  endtask

  // multiply, then hold an add against the stall and count busy cycles
  task automatic mul(input logic [15:0] code, input logic nra,
      input logic [31:0] a, b, input logic [63:0] ep, input int nb);
    int n;
    model.regs[1] = a;
    model.regs[2] = b;
    issue(code, nra);
    wbd = WB_DATA;
    wb2d = WB2_DATA;
    chk({WB_IDX, WB2_IDX}, {code[11:8], code[7:4]});
    chk({PRODUCT_HIGH, PRODUCT_LOW}, ep);
    INSN = 16'h312c;
    // every edge inside the loop is a stall edge: the held add is not taken
    for (n = 0; n < 8 && BUSY === 1'b1; n++) begin
      @(posedge CORE_CLK) #1;
      chk(WB_EN, 64'h0);
    end
    chk(n, nb);
    @(posedge CORE_CLK) #1;
    chk(WB_EN, 64'h1);
  endtask

  task automatic t_arith;
    op(16'h312c, 1, 32'h7fffffff, 32'h1, 1, 32'h80000000, 1);
    op(16'h71ff, 0, 32'h5, 32'h0, 1, 32'h4, 0);
    op(16'h312e, 1, 32'hffffffff, 32'h0, 1, 32'h0, 1);
    op(16'h312f, 0, 32'h7fffffff, 32'h1, 1, 32'h80000000, 1);
    op(16'h3128, 1, 32'h5, 32'h7, 1, 32'hfffffffe, 1);
    op(16'h312a, 1, 32'h5, 32'h4, 1, 32'h0, 0);
    op(16'h312b, 0, 32'h80000000, 32'h1, 1, 32'h7fffffff, 1);
    op(16'h612b, 1, 32'h0, 32'h1, 1, 32'hffffffff, 1);
    op(16'h612a, 1, 32'h0, 32'h0, 1, 32'hffffffff, 1);
  endtask

  task automatic t_compare;
    op(16'h3120, 1, 32'h5, 32'h6, 0, 32'h0, 0);
    op(16'h8805, 0, 32'h5, 32'h0, 0, 32'h0, 1);
    op(16'h3122, 0, 32'h2, 32'h2, 0, 32'h0, 1);
    op(16'h3126, 1, 32'h2, 32'h2, 0, 32'h0, 0);
    op(16'h3126, 0, 32'h80000000, 32'h1, 0, 32'h0, 1);
    op(16'h3127, 1, 32'h80000000, 32'h1, 0, 32'h0, 0);
    op(16'h3123, 0, 32'h1, 32'h1, 0, 32'h0, 1);
    op(16'h4115, 1, 32'h0, 32'h0, 0, 32'h0, 0);
    op(16'h4111, 0, 32'h0, 32'h0, 0, 32'h0, 1);
    op(16'h212c, 0, 32'h11223344, 32'h99883355, 0, 32'h0, 1);
    op(16'h212c, 1, 32'h11223344, 32'h44332211, 0, 32'h0, 0);
    op(16'h4110, 0, 32'h1, 32'h0, 1, 32'h0, 1);
    op(16'h4110, 1, 32'h2, 32'h0, 1, 32'h1, 0);
  endtask

  task automatic t_extend;
    op(16'h612e, 1, 32'h0, 32'h180, 1, 32'hffffff80, 1);
    op(16'h612f, 0, 32'h0, 32'h18000, 1, 32'hffff8000, 0);
    op(16'h612c, 0, 32'h0, 32'h1ff, 1, 32'hff, 0);
    op(16'h612d, 0, 32'h0, 32'h1ffff, 1, 32'hffff, 0);
  endtask

  task automatic t_divide;
    op(16'h2127, 0, 32'h80000000, 32'h0, 0, 32'h0, 1);
    chk({DIVIDEND_SIGN, DIVISOR_SIGN}, 64'h2);
    op(16'h0019, 1, 32'h0, 32'h0, 0, 32'h0, 0);
    chk({DIVIDEND_SIGN, DIVISOR_SIGN}, 64'h0);
    op(16'h3124, 0, 32'h80000000, 32'h1, 1, 32'hffffffff, 1);
  endtask

  task automatic t_multiply;
    mul(16'h312d, 0, 32'hffffffff, 32'h2, 64'hffffffff_fffffffe, 1);
    mul(16'h3125, 1, 32'hffffffff, 32'h2, 64'h1_fffffffe, 4);
    mul(16'h0127, 0, 32'h3, 32'h80000001, 64'h1_80000003, 1);
    mul(16'h212f, 0, 32'h1234ffff, 32'h2, 64'h1_fffffffe, 0);
    mul(16'h212e, 1, 32'hffff, 32'hffff0002, 64'h1_0001fffe, 2);
  endtask

  task automatic t_mac;
    mul(16'h3125, 0, 32'h0, 32'h0, 64'h0, 1);
    mul(16'h012f, 0, 32'h100, 32'h200, 64'h200, 1);
    chk({wbd, wb2d}, 64'h104_00000204);
    mul(16'h412f, 1, 32'hffff0, 32'h20, 64'h1fe, 4);
    chk({wbd, wb2d}, 64'hffff2_00000022);
  endtask

  // reset in the middle of a stall clears it, the flag, the write strobe and the product
  task automatic t_reset;
    model.regs[1] = 32'h5;
    model.regs[2] = 32'h7;
    issue(16'h0127, 1'b1);
    RST_B = 1'b0;
    INSN_VALID = 1'b0;
    @(posedge CORE_CLK) #1;
    chk({BUSY, COND_FLAG, WB_EN}, 64'h0);
    RST_B = 1'b1;
    @(posedge CORE_CLK) #1;
    chk({PRODUCT_HIGH, PRODUCT_LOW}, 64'h0);
  endtask

  initial begin
    repeat (2) @(posedge CORE_CLK);
    #1 RST_B = 1'b1;
    @(posedge CORE_CLK) #1;
    t_arith;
    t_compare;
    t_extend;
    t_divide;
    t_multiply;
    t_mac;
    t_reset;
    t_arith;
    test_done;
  end
endmodule // test_integer_arith_unit

bind iau_core iau_core_assertions u_chk (.CORE_CLK, .RST_B, .INSN_VALID,
  .INSN, .RN_VAL, .RM_VAL, .NEXT_READS_ACC, .WB_EN, .WB2_EN, .COND_FLAG,
  .DIVIDEND_SIGN, .DIVISOR_SIGN, .BUSY);
`default_nettype wire
